/* logic/prhg_top.sv */
// rng front end: entropy health tests, output gate, apb registers
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module prhg_top #(
    parameter int WORD_W   = prhg_pkg::WORD_W,
    parameter int DEPTH    = prhg_pkg::FIFO_DEPTH,
    parameter int WIN_BITS = prhg_pkg::ONLINE_WIN
) (
    input  wire logic        clk_i,          // 125 MHz system clock
    input  wire logic        rst_n_i,        // async reset, low
    // raw entropy from the analogue source, and the post-processing check
    input  wire logic        raw_bit_i,      // raw random bit, async
    input  wire logic        raw_strobe_i,   // raw bit present, async
    input  wire logic        pp_check_ok_i,  // post-processing self check
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // direct word stream to the consumer
    output logic [WORD_W-1:0] rnd_data_o,    // random word
    output logic              rnd_valid_o,   // word valid
    input  wire logic         rnd_ready_i,   // consumer takes word
    output logic              gate_open_o    // output gate state
);
    // --------
    // input synchronisers
    // --------
    logic [1:0] bit_sync_reg;       // raw bit, two stages
    logic [1:0] stb_sync_reg;       // raw strobe, two stages
    logic [1:0] pp_sync_reg;        // self check, two stages
    logic       stb_prev_reg;       // strobe after sync, delayed

    // two flops before any logic sees the pins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_sync_reg <= 2'h0;
            stb_sync_reg <= 2'h0;
            pp_sync_reg  <= 2'h3;
            stb_prev_reg <= 1'b0;
        end else begin
            bit_sync_reg <= {bit_sync_reg[0], raw_bit_i};
            stb_sync_reg <= {stb_sync_reg[0], raw_strobe_i};
            pp_sync_reg  <= {pp_sync_reg[0], pp_check_ok_i};
            stb_prev_reg <= stb_sync_reg[1];
        end
    end

    // one new bit per strobe rise
    logic raw_b;       // synchronised raw bit
    logic raw_new;     // one new raw bit this cycle
    logic pp_ok;       // post-processing healthy
    assign raw_b   = bit_sync_reg[1];
    assign raw_new = stb_sync_reg[1] & ~stb_prev_reg;
    assign pp_ok   = pp_sync_reg[1];

    // --------
    // apb decode
    // --------
    logic apb_acc;       // access phase
    logic wr_ctrl;       // control write
    logic rd_data;       // data pop read
    logic hit;           // mapped address
    assign apb_acc  = psel_i & penable_i;
    assign wr_ctrl  = apb_acc & pwrite_i & (paddr_i == prhg_pkg::OFF_CTRL);
    assign rd_data  = apb_acc & ~pwrite_i & (paddr_i == prhg_pkg::OFF_DATA);
    assign hit      = (paddr_i == prhg_pkg::OFF_CTRL)
                    | (paddr_i == prhg_pkg::OFF_STATUS)
                    | (paddr_i == prhg_pkg::OFF_DATA)
                    | (paddr_i == prhg_pkg::OFF_LEVEL);
    // no wait states, error on unmapped address
    assign pready_o  = 1'b1;
    assign pslverr_o = apb_acc & ~hit;

    logic cmd_start;     // start pulse
    logic cmd_stop;      // shutdown pulse
    logic cmd_trig;      // online test trigger pulse
    // start, stop and trigger bits act as one-cycle commands
    assign cmd_start = wr_ctrl & pwdata_i[prhg_pkg::CTRL_START];
    assign cmd_stop  = wr_ctrl & pwdata_i[prhg_pkg::CTRL_STOP];
    assign cmd_trig  = wr_ctrl & pwdata_i[prhg_pkg::CTRL_TRIG];

    logic variant_reg;   // alternative variant checks on
    // variant bit kept until the next control write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            variant_reg <= 1'b0;
        end else if (wr_ctrl) begin
            variant_reg <= pwdata_i[prhg_pkg::CTRL_VARIANT];
        end
    end

    // --------
    // state machine
    // --------
    prhg_pkg::prhg_state_e state_reg;
    prhg_pkg::prhg_state_e state_next;
    prhg_pkg::prhg_flags_s flags_reg;     // sticky failure flags
    prhg_pkg::prhg_flags_s flags_set;     // detections this cycle
    logic any_fail;                        // any detection now
    logic test_done;                       // online window finished
    logic test_pass;                       // window within limits
    logic testing_reg;                     // online window active

    // any detection closes the gate at once
    assign any_fail = |flags_set;

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            prhg_pkg::ST_IDLE: begin
                if (cmd_start) begin
                    state_next = prhg_pkg::ST_BOOT;
                end
            end
            prhg_pkg::ST_BOOT: begin
                if (cmd_stop) begin
                    state_next = prhg_pkg::ST_IDLE;
                end else if (any_fail) begin
                    state_next = prhg_pkg::ST_FAIL;
                end else if (test_done && test_pass) begin
                    state_next = prhg_pkg::ST_OPER;
                end
            end
            prhg_pkg::ST_OPER: begin
                if (cmd_stop) begin
                    state_next = prhg_pkg::ST_IDLE;
                end else if (any_fail) begin
                    state_next = prhg_pkg::ST_FAIL;
                end
            end
            prhg_pkg::ST_FAIL: begin
                if (cmd_stop) begin
                    state_next = prhg_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = prhg_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= prhg_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // tests look at bits only while running
    logic running;     // raw bits are being examined
    assign running = (state_reg == prhg_pkg::ST_BOOT)
                   | (state_reg == prhg_pkg::ST_OPER);

    // --------
    // total failure and health tests: run length of equal bits
    // --------
    logic [5:0] run_reg;     // current run of equal bits
    logic       last_reg;    // previous raw bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_reg  <= 6'h00;
            last_reg <= 1'b0;
        end else if (!running) begin
            run_reg  <= 6'h00;
        end else if (raw_new) begin
            last_reg <= raw_b;
            if (raw_b == last_reg && run_reg != 6'h3F) begin
                run_reg <= run_reg + 6'h01;
            end else if (raw_b != last_reg) begin
                run_reg <= 6'h00;
            end
        end
    end

    assign flags_set.total  = running & raw_new & (raw_b == last_reg)
                            & (run_reg >= 6'(prhg_pkg::TOTAL_RUN - 2));
    assign flags_set.health = running & variant_reg & raw_new
                            & (raw_b == last_reg)
                            & (run_reg >= 6'(prhg_pkg::HEALTH_RUN - 2));
    assign flags_set.malf   = running & variant_reg & ~pp_ok;

    // --------
    // online test: ones count over a window
    // --------
    logic [8:0] win_cnt_reg;   // bits seen in window
    logic [8:0] ones_reg;      // ones seen in window

    // window at boot and on a trigger in ST_OPER while no window is open
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            testing_reg <= 1'b0;
            win_cnt_reg <= 9'h000;
            ones_reg    <= 9'h000;
        end else if (!running) begin
            testing_reg <= cmd_start;
            win_cnt_reg <= 9'h000;
            ones_reg    <= 9'h000;
        end else if (test_done) begin
            testing_reg <= 1'b0;
            win_cnt_reg <= 9'h000;
            ones_reg    <= 9'h000;
        end else if (cmd_trig && !testing_reg) begin
            testing_reg <= 1'b1;
        end else if (testing_reg && raw_new) begin
            win_cnt_reg <= win_cnt_reg + 9'h001;
            ones_reg    <= ones_reg + 9'(raw_b);
        end
    end

    // window ends after the last counted bit
    assign test_done = testing_reg & (win_cnt_reg == 9'(WIN_BITS));
    assign test_pass = (ones_reg >= 9'(prhg_pkg::ONLINE_LO))
                     & (ones_reg <= 9'(prhg_pkg::ONLINE_HI));
    assign flags_set.online = running & test_done & ~test_pass;

    // sticky flags, cleared only by reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_reg | flags_set;
        end
    end

    // --------
    // word assembly
    // --------
    logic [WORD_W-1:0] shift_reg;   // bits being gathered
    logic [4:0]        nbits_reg;   // bits gathered
    logic              word_full;   // shift holds a whole word
    logic              fifo_ready;  // fifo can take a word
    logic              gate_open;   // output gate
    assign word_full = (nbits_reg == 5'(WORD_W));
    assign gate_open = (state_reg == prhg_pkg::ST_OPER) & ~any_fail;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
            nbits_reg <= 5'h00;
        end else if (!gate_open) begin
            // discard bits gathered around a failure
            nbits_reg <= 5'h00;
        end else if (word_full) begin
            if (fifo_ready) begin
                nbits_reg <= 5'h00;
            end
        end else if (raw_new) begin
            shift_reg <= {shift_reg[WORD_W-2:0], raw_b};
            nbits_reg <= nbits_reg + 5'h01;
        end
    end

    // --------
    // output buffer
    // --------
    logic [WORD_W-1:0] fifo_data;     // head word
    logic              fifo_valid;    // head valid
    logic              fifo_pop;      // head taken
    logic [$clog2(DEPTH):0] fifo_lvl; // words held
    // stream port or data read pops the head
    assign fifo_pop = (rnd_ready_i | rd_data) & gate_open;

    prhg_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) prhg_fifo_i (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (~gate_open),
        .in_data_i   (shift_reg),
        .in_valid_i  (word_full & gate_open),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .level_o     (fifo_lvl)
    );

    assign rnd_valid_o = fifo_valid & gate_open;
    assign rnd_data_o  = rnd_valid_o ? fifo_data : '0;
    assign gate_open_o = gate_open;

    // --------
    // read data
    // --------
    logic [31:0] status_w;   // status word
    // status word layout
    assign status_w = {24'h000000, testing_reg, rnd_valid_o,
                       flags_reg.malf, flags_reg.health,
                       flags_reg.online, flags_reg.total,
                       running, gate_open};

    // read data select by address
    always_comb begin
        if (paddr_i == prhg_pkg::OFF_CTRL) begin
            prdata_o = {28'h0000000, variant_reg, 3'h0};
        end else if (paddr_i == prhg_pkg::OFF_STATUS) begin
            prdata_o = status_w;
        end else if (paddr_i == prhg_pkg::OFF_DATA) begin
            prdata_o = {16'h0000, rnd_data_o};
        end else if (paddr_i == prhg_pkg::OFF_LEVEL) begin
            prdata_o = 32'(fifo_lvl);
        end else begin
            prdata_o = 32'h0000_0000;
        end
    end

endmodule : prhg_top

/* logic/prhg_pkg.sv */
// shared constants, types and register map of the rng health gate
package prhg_pkg;

    // --------
    // register byte offsets
    // --------
    localparam logic [7:0] OFF_CTRL   = 8'h00;  // control bits
    localparam logic [7:0] OFF_STATUS = 8'h04;  // state and sticky flags
    localparam logic [7:0] OFF_DATA   = 8'h08;  // pop one random word
    localparam logic [7:0] OFF_LEVEL  = 8'h0C;  // fifo fill level

    // --------
    // control field positions
    // --------
    localparam int CTRL_START   = 0;  // write 1: start generator
    localparam int CTRL_STOP    = 1;  // write 1: shutdown
    localparam int CTRL_TRIG    = 2;  // write 1: trigger online test
    localparam int CTRL_VARIANT = 3;  // alternative variant enable

    // --------
    // status field positions
    // --------
    localparam int ST_OPEN      = 0;  // output gate open
    localparam int ST_RUN       = 1;  // generator running
    localparam int ST_TOTAL     = 2;  // sticky total failure
    localparam int ST_ONLINE    = 3;  // sticky online defect
    localparam int ST_HEALTH    = 4;  // sticky health failure
    localparam int ST_MALF      = 5;  // sticky malfunction
    localparam int ST_AVAIL     = 6;  // word available
    localparam int ST_TESTING   = 7;  // online test in progress

    // --------
    // sizes and test thresholds
    // --------
    localparam int WORD_W       = 16; // random word width
    localparam int FIFO_DEPTH   = 8;  // words buffered
    localparam int TOTAL_RUN    = 32; // equal raw bits = total failure
    localparam int ONLINE_WIN   = 256;// online test window in bits
    localparam int ONLINE_LO    = 96; // least ones in window
    localparam int ONLINE_HI    = 160;// most ones in window
    localparam int HEALTH_RUN   = 12; // equal bits = severe degradation
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // --------
    // generator states, one-hot
    // --------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,  // stopped, gate closed
        ST_BOOT  = 4'b0010,  // start-up online test
        ST_OPER  = 4'b0100,  // delivering words
        ST_FAIL  = 4'b1000   // failure found, gate closed
    } prhg_state_e;

    // --------
    // sticky failure flags
    // --------
    typedef struct packed {
        logic total;   // entropy source stuck
        logic online;  // statistical defect
        logic health;  // severe degradation
        logic malf;    // post-processing malfunction
    } prhg_flags_s;

endpackage : prhg_pkg

/* logic/prhg_fifo.sv */
// parameterised word fifo with valid and ready on both sides
`timescale 1ns/1ps
module prhg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,    // system clock
    input  wire logic             rst_n_i,  // async reset, low
    input  wire logic             flush_i,  // drop all contents
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];     // word storage
    logic [AW-1:0]    wr_ptr_reg;      // write index
    logic [AW-1:0]    rd_ptr_reg;      // read index
    logic [AW:0]      cnt_reg;         // words held
    logic             push;            // word accepted
    logic             pop;             // word taken

    // honest full and empty
    assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem[rd_ptr_reg];
    assign level_o     = cnt_reg;

    // storage write, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else if (flush_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : prhg_fifo

/* tb/prhg_top_sva.sv */
// checker of gate, stream and control rules of the rng block
`timescale 1ns/1ps
module prhg_top_sva #(
    parameter int WORD_W = 16
) (
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              raw_bit_i,
    input wire logic              raw_strobe_i,
    input wire logic              pp_check_ok_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [7:0]        paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic [WORD_W-1:0] rnd_data_o,
    input wire logic              rnd_valid_o,
    input wire logic              rnd_ready_i,
    input wire logic              gate_open_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // --------
    // helper logic: control writes, raw run length, boot time
    // --------
    wire logic acc     = psel_i && penable_i;
    wire logic wr_ctrl = acc && pwrite_i && paddr_i == prhg_pkg::OFF_CTRL;
    wire logic rd_data = acc && !pwrite_i && paddr_i == prhg_pkg::OFF_DATA;
    wire logic start_w = wr_ctrl && pwdata_i[prhg_pkg::CTRL_START];
    wire logic stop_w  = wr_ctrl && pwdata_i[prhg_pkg::CTRL_STOP];
    logic        strb_q;   // strobe of last cycle
    logic        bit_q;    // last raw bit taken
    logic        var_q;    // variant bit as written
    logic        armed_q;  // started and not stopped since
    logic [5:0]  run_q;    // equal raw bits in a row
    logic [10:0] since_q;  // cycles since the start that set armed_q
    // run length counts on each strobe rise, saturating
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strb_q  <= 1'b0;
            bit_q   <= 1'b0;
            var_q   <= 1'b0;
            armed_q <= 1'b0;
            run_q   <= 6'h00;
            since_q <= 11'h000;
        end else begin
            strb_q  <= raw_strobe_i;
            armed_q <= start_w | (armed_q & ~stop_w);
            since_q <= (start_w && !armed_q) ? 11'h000 :
                       (since_q == 11'h7FF) ? since_q : since_q + 11'h001;
            if (wr_ctrl) var_q <= pwdata_i[prhg_pkg::CTRL_VARIANT];
            if (raw_strobe_i && !strb_q) begin
                bit_q <= raw_bit_i;
                run_q <= (raw_bit_i != bit_q) ? 6'h01 :
                         (run_q == 6'h3F) ? run_q : run_q + 6'h01;
            end
        end
    end
    chk_valid_gated: assert property (rnd_valid_o |-> gate_open_o)
        else $error("word valid while gate closed");
    chk_idle_zero: assert property (!rnd_valid_o |-> rnd_data_o == '0)
        else $error("data not zero without valid");
    chk_word_hold: assert property ((rnd_valid_o && !rnd_ready_i && !rd_data)
        ##1 gate_open_o |-> rnd_valid_o && $stable(rnd_data_o))
        else $error("untaken word changed");
    chk_boot_first: assert property (gate_open_o |-> armed_q
        && since_q > 11'h384) else $error("gate open without boot test");
    chk_stop_close: assert property (stop_w |=> !gate_open_o [*8])
        else $error("gate open after shutdown");
    chk_total_close: assert property (run_q >= 6'h22 |-> !gate_open_o)
        else $error("gate open with stuck source");
    chk_health_close: assert property (var_q && run_q >= 6'h0E
        |-> !gate_open_o) else $error("gate open with degraded source");
    chk_malf_close: assert property ((var_q && !pp_check_ok_i) [*4]
        |-> !gate_open_o) else $error("gate open with malfunction");
    cover property ($rose(gate_open_o));
    cover property (rnd_valid_o && rnd_ready_i);
    cover property (run_q >= 6'h22);
endmodule : prhg_top_sva

/* tb/prhg_src_model.sv */
// entropy source model: raw bit and strobe patterns
`timescale 1ns/1ps
module prhg_src_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] mode_i,   // fair, stuck, long run, biased
    output logic            raw_bit_o,
    output logic            raw_strobe_o
);
    // patterns sent msb first, sixteen bits repeating
    wire logic [15:0] pat = (mode_i == 2'h0) ? 16'h6666 :
                            (mode_i == 2'h1) ? 16'hFFFF :
                            (mode_i == 2'h2) ? 16'hFFFC : 16'hEEEE;
    logic [1:0] ph_q;   // two clocks low, two high
    logic [3:0] idx_q;  // bit position in pattern
    // bit changes only while strobe is low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_q         <= 2'h0;
            idx_q        <= 4'h0;
            raw_bit_o    <= 1'b0;
            raw_strobe_o <= 1'b0;
        end else begin
            ph_q         <= ph_q + 2'h1;
            raw_strobe_o <= ph_q[0] ^ ph_q[1];
            if (ph_q == 2'h0) begin
                raw_bit_o <= pat[4'hF - idx_q];
                idx_q     <= idx_q + 4'h1;
            end
        end
    end
endmodule : prhg_src_model

/* tb/tb_physical_rng_health_gate.sv */
// self-checking bench of the rng health gate
`timescale 1ns/1ps
module tb_physical_rng_health_gate;
    logic        clk_i = 1'b0, rst_n_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, last_err, rnd_valid, gate;
    logic        raw_bit, raw_strobe, rnd_ready = 1'b0, pp_ok = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic [15:0] rnd_data;
    int          n_mismatch = 0, cmp_count = 0;
    localparam logic [31:0] C_GO = 32'h1, C_STOP = 32'h2;
    localparam logic [31:0] C_TRIG = 32'h4, C_VAR = 32'h8;
    always #4 clk_i = ~clk_i;
    prhg_src_model prhg_src_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .mode_i(mode), .raw_bit_o(raw_bit), .raw_strobe_o(raw_strobe));
    prhg_top prhg_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .raw_bit_i(raw_bit), .raw_strobe_i(raw_strobe),
        .pp_check_ok_i(pp_ok), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rnd_data_o(rnd_data), .rnd_valid_o(rnd_valid),
        .rnd_ready_i(rnd_ready), .gate_open_o(gate));
    // --------
    // shared tasks: verdict, compare, bus cycle, waits
    // --------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic tmo();
        n_mismatch++;
        $display("CHECK FAILED wait limit exp done got timeout");
        report_and_stop();
    endtask : tmo
    // apb master: setup, then access held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) tmo();
    endtask : apb
    task automatic ctl(input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, prhg_pkg::OFF_CTRL, d, q);
    endtask : ctl
    task automatic st_bit(input int b, input logic e);
        logic [31:0] q;
        apb(1'b0, prhg_pkg::OFF_STATUS, 32'h0, q);
        chk("status bit", e, q[b]);
    endtask : st_bit
    // wait on gate (which 0) or word valid (which 1)
    task automatic wait_for(input logic which, v, input int lim);
        int n;
        n = 0;
        while ((which ? rnd_valid : gate) !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if ((which ? rnd_valid : gate) !== v) tmo();
    endtask : wait_for
    task automatic hold_closed(input int n);
        int k;
        k = 0;
        repeat (n) begin
            @(posedge clk_i);
            k += (gate !== 1'b0);
        end
        chk("gate opened", 0, k);
    endtask : hold_closed
    function automatic logic ok_word(input logic [15:0] w);
        return w inside {16'h6666, 16'hCCCC, 16'h9999, 16'h3333};
    endfunction : ok_word
    // --------
    // scenarios
    // --------
    task automatic t_reset();
        logic [31:0] q;
        chk("valid", 0, rnd_valid);
        apb(1'b0, prhg_pkg::OFF_STATUS, 32'h0, q);
        chk("status", 0, q);
        apb(1'b0, 8'h10, 32'h0, q);
        chk("unmapped err", 1, last_err);
        chk("unmapped data", 0, q);
        $display("test reset done");
    endtask : t_reset
    task automatic t_boot();
        logic [31:0] q;
        int n;
        n = 0;
        q = 0;
        ctl(C_GO);
        hold_closed(400);
        st_bit(prhg_pkg::ST_TESTING, 1);
        wait_for(0, 1, 3000);
        while (q !== 32'h8 && n < 400) begin
            apb(1'b0, prhg_pkg::OFF_LEVEL, 32'h0, q);
            n++;
        end
        if (q !== 32'h8) tmo();
        chk("word", 1, ok_word(rnd_data));
        repeat (200) @(posedge clk_i);
        apb(1'b0, prhg_pkg::OFF_LEVEL, 32'h0, q);
        chk("level full", 8, q);
        rnd_ready <= 1'b1;
        repeat (8) @(posedge clk_i);
        rnd_ready <= 1'b0;
        apb(1'b0, prhg_pkg::OFF_LEVEL, 32'h0, q);
        chk("level drained", 1, q < 32'h2);
        ctl(C_TRIG);
        st_bit(prhg_pkg::ST_TESTING, 1);
        wait_for(1, 1, 300);
        apb(1'b0, prhg_pkg::OFF_DATA, 32'h0, q);
        chk("data word", 1, ok_word(q[15:0]));
        $display("test boot done");
    endtask : t_boot
    task automatic t_total();
        mode <= 2'h1;
        wait_for(0, 0, 400);
        chk("valid", 0, rnd_valid);
        st_bit(prhg_pkg::ST_TOTAL, 1);
        ctl(C_STOP);
        st_bit(prhg_pkg::ST_RUN, 0);
        ctl(C_GO);
        hold_closed(1500);
        ctl(C_STOP);
        mode <= 2'h3;
        ctl(C_GO);
        hold_closed(1500);
        st_bit(prhg_pkg::ST_ONLINE, 1);
        ctl(C_STOP);
        $display("test failures done");
    endtask : t_total
    task automatic t_variant();
        mode <= 2'h0;
        ctl(C_GO | C_VAR);
        wait_for(0, 1, 3000);
        mode <= 2'h2;
        wait_for(0, 0, 200);
        st_bit(prhg_pkg::ST_HEALTH, 1);
        ctl(C_STOP | C_VAR);
        mode <= 2'h0;
        ctl(C_GO | C_VAR);
        wait_for(0, 1, 3000);
        pp_ok <= 1'b0;
        wait_for(0, 0, 50);
        st_bit(prhg_pkg::ST_MALF, 1);
        pp_ok <= 1'b1;
        ctl(C_STOP | C_VAR);
        $display("test variant done");
    endtask : t_variant
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_boot();
        t_total();
        t_variant();
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        report_and_stop();
    end
endmodule : tb_physical_rng_health_gate
bind prhg_top prhg_top_sva #(.WORD_W(WORD_W)) prhg_top_sva_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .raw_bit_i(raw_bit_i),
    .raw_strobe_i(raw_strobe_i), .pp_check_ok_i(pp_check_ok_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rnd_data_o(rnd_data_o),
    .rnd_valid_o(rnd_valid_o), .rnd_ready_i(rnd_ready_i),
    .gate_open_o(gate_open_o));
